// file: logic/scbw_map.svh
// Operation
// - two-bit brown-out reset level at bits 1:0 selects threshold 0 to 3, resets to zero
// - two-bit brown-out interrupt level at bits 3:2 selects 1 to 3; code 0 is reserved
// - brown-out interrupt goes to the controller; chip reset only while bit 4 is set
// - 26-bit tick calibration at bits 25:0, reset 0x04, presented to the core tick timer
// - eight-bit latency at bits 7:0, reset 0x010, least cycles before interrupt response
// - interrupt response always waits at least the latency count, even when it could go sooner
// - peripheral interrupt numbered by bits 4:0 becomes non-maskable while bit 31 is set
// - with bit 31 clear no peripheral interrupt is delivered as non-maskable
// - a routed interrupt still raises its normal interrupt as well
// - wake edge bits 11:0 and 12 pick falling (0) or rising (1) pin edge
// - edge bit n drives wake-up interrupt n, thirteen in all, all reset to falling
// - a selected pin edge sets the latched wake-up state; it is cleared before use
`ifndef SCBW_MAP_SVH
`define SCBW_MAP_SVH

// ==========================================================================
// register byte addresses
`define SCBW_ADDR_BOD      32'h4004_8150
`define SCBW_ADDR_TICK     32'h4004_8154
`define SCBW_ADDR_LAT      32'h4004_8170
`define SCBW_ADDR_NMI      32'h4004_8174
`define SCBW_ADDR_WAKE     32'h4004_8200
`define SCBW_ADDR_EVSTS    32'h4004_8240
`define SCBW_ADDR_EVMSK    32'h4004_8244

// ==========================================================================
// field positions
`define SCBW_BOD_RLEV_LSB  0
`define SCBW_BOD_ILEV_LSB  2
`define SCBW_BOD_RENA_BIT  4
`define SCBW_NMI_EN_BIT    31
`define SCBW_EV_BOD_IRQ    0
`define SCBW_EV_BOD_RST    1
`define SCBW_EV_WAKE       2
`define SCBW_EV_NMI        3
`define SCBW_EV_W          4

// ==========================================================================
// reset values
`define SCBW_RST_LEVEL     2'h0
`define SCBW_RST_TICK      26'h000_0004
`define SCBW_RST_LAT       8'h10
`define SCBW_RST_NMI_NUM   5'h00
`define SCBW_RST_WAKE      13'h0000
`define SCBW_ILEV_RSVD     2'h0

`endif

// file: logic/scbw_pkg.sv
`default_nettype none
package scbw_pkg;
  // threshold selection carried to the comparators
  typedef logic [1:0] scbw_level_type;
  // minimum-latency gate states
  typedef enum logic [1:0] {
    SCBW_LAT_IDLE  = 2'b00,
    SCBW_LAT_COUNT = 2'b01,
    SCBW_LAT_GRANT = 2'b10
  } scbw_lat_state_type;
endpackage
`default_nettype wire

// file: logic/scbw_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "scbw_map.svh"
module scbw_regs #(
  parameter int NUM_WAKE = 13,
  parameter int NUM_PIRQ = 32
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       arst_n_in,
  input  wire logic [31:0]                reg_addr_in,
  input  wire logic [31:0]                reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output var  logic [31:0]                reg_rdata_out,
  input  wire logic                       bod_irq_cross_in,
  input  wire logic                       bod_rst_cross_in,
  output var  scbw_pkg::scbw_level_type   brownout_reset_level_out,
  output var  scbw_pkg::scbw_level_type   brownout_irq_level_out,
  output var  logic                       bod_irq_out,
  output var  logic                       chip_reset_req_out,
  output var  logic [25:0]                core_tick_calibration_out,
  input  wire logic                       irq_req_in,
  output logic                            irq_grant_out,
  input  wire logic [NUM_PIRQ-1:0]        periph_irq_in,
  output var  logic [NUM_PIRQ-1:0]        normal_irq_out,
  output var  logic                       nmi_out,
  input  wire logic [NUM_WAKE-1:0]        wake_pin_in,
  input  wire logic [NUM_WAKE-1:0]        wake_clear_in,
  output var  logic [NUM_WAKE-1:0]        wake_irq_out,
  output logic                            irq_out
);
  import scbw_pkg::*;

  // refuse sizes that the fixed register layout cannot carry
  if (NUM_WAKE != 13 || NUM_PIRQ != 32) begin : g_bad_size
    $error("scbw_regs: only 13 wake inputs and 32 peripheral interrupts are supported");
  end

  // ==========================================================================
  // register state
  scbw_level_type     rlev_q;
  scbw_level_type     ilev_q;
  logic               rena_q;
  logic [25:0]        tick_q;
  logic [7:0]         lat_q;
  logic [4:0]         nmi_num_q;
  logic               nmi_en_q;
  logic [12:0]        wake_edge_q;
  logic [`SCBW_EV_W-1:0] ev_sts_q;
  logic [`SCBW_EV_W-1:0] ev_msk_q;
  logic [31:0]        rdata_d;

  // address decode
  wire sel_bod   = (reg_addr_in == `SCBW_ADDR_BOD);
  wire sel_tick  = (reg_addr_in == `SCBW_ADDR_TICK);
  wire sel_lat   = (reg_addr_in == `SCBW_ADDR_LAT);
  wire sel_nmi   = (reg_addr_in == `SCBW_ADDR_NMI);
  wire sel_wake  = (reg_addr_in == `SCBW_ADDR_WAKE);
  wire sel_evsts = (reg_addr_in == `SCBW_ADDR_EVSTS);
  wire sel_evmsk = (reg_addr_in == `SCBW_ADDR_EVMSK);

  // read mux, reserved bits and unmapped addresses give zero
  assign rdata_d =
      sel_bod   ? {27'h0, rena_q, ilev_q, rlev_q} :
      sel_tick  ? {6'h00, tick_q} :
      sel_lat   ? {24'h00_0000, lat_q} :
      sel_nmi   ? {nmi_en_q, 26'h000_0000, nmi_num_q} :
      sel_wake  ? {19'h0_0000, wake_edge_q} :
      sel_evsts ? {28'h000_0000, ev_sts_q} :
      sel_evmsk ? {28'h000_0000, ev_msk_q} : 32'h0000_0000;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_d : 32'h0000_0000;
    end
  end

  // writable fields, reserved bits dropped
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rlev_q      <= `SCBW_RST_LEVEL;
      ilev_q      <= `SCBW_RST_LEVEL;
      rena_q      <= 1'b0;
      tick_q      <= `SCBW_RST_TICK;
      lat_q       <= `SCBW_RST_LAT;
      nmi_num_q   <= `SCBW_RST_NMI_NUM;
      nmi_en_q    <= 1'b0;
      wake_edge_q <= `SCBW_RST_WAKE;
      ev_msk_q    <= 4'h0;
    end else if (reg_wr_in) begin
      if (sel_bod) begin
        rlev_q <= reg_wdata_in[`SCBW_BOD_RLEV_LSB +: 2];
        ilev_q <= reg_wdata_in[`SCBW_BOD_ILEV_LSB +: 2];
        rena_q <= reg_wdata_in[`SCBW_BOD_RENA_BIT];
      end
      if (sel_tick) begin
        tick_q <= reg_wdata_in[25:0];
      end
      if (sel_lat) begin
        lat_q <= reg_wdata_in[7:0];
      end
      if (sel_nmi) begin
        nmi_num_q <= reg_wdata_in[4:0];
        nmi_en_q  <= reg_wdata_in[`SCBW_NMI_EN_BIT];
      end
      if (sel_wake) begin
        wake_edge_q <= reg_wdata_in[12:0];
      end
      if (sel_evmsk) begin
        ev_msk_q <= reg_wdata_in[`SCBW_EV_W-1:0];
      end
    end
  end

  // written fields follow the write strobe into the outputs
  AST_LEVEL_WR: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ($past(reg_wr_in && sel_bod) |-> (brownout_reset_level_out == $past(reg_wdata_in[1:0])) &&
     (brownout_irq_level_out == $past(reg_wdata_in[3:2])))) else $error("level field not written");
  AST_WAKE_WR: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ($past(reg_wr_in && sel_wake) |-> wake_edge_q == $past(reg_wdata_in[12:0])))
    else $error("edge select not written");

  // ==========================================================================
  // brown-out detector path
  logic [1:0] bod_irq_sync_q;
  logic [1:0] bod_rst_sync_q;
  logic       bod_irq_prev_q;

  // two-flop synchronisers for the comparator outputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bod_irq_sync_q <= 2'h0;
      bod_rst_sync_q <= 2'h0;
      bod_irq_prev_q <= 1'b0;
    end else begin
      bod_irq_sync_q <= {bod_irq_sync_q[0], bod_irq_cross_in};
      bod_rst_sync_q <= {bod_rst_sync_q[0], bod_rst_cross_in};
      bod_irq_prev_q <= bod_irq_sync_q[1];
    end
  end

  // reserved interrupt level keeps the interrupt quiet
  wire ilev_valid = (ilev_q != `SCBW_ILEV_RSVD);
  wire bod_irq_d  = bod_irq_sync_q[1] & ilev_valid;
  wire bod_rst_d  = bod_rst_sync_q[1] & rena_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bod_irq_out        <= 1'b0;
      chip_reset_req_out <= 1'b0;
    end else begin
      bod_irq_out        <= bod_irq_d;
      chip_reset_req_out <= bod_rst_d;
    end
  end

  // threshold selections and calibration straight from the registers
  assign brownout_reset_level_out  = rlev_q;
  assign brownout_irq_level_out    = ilev_q;
  assign core_tick_calibration_out = tick_q;

  // brown-out request gating
  AST_BOD_RST_GATE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!rena_q |=> !chip_reset_req_out)) else $error("reset request while reset disabled");
  AST_BOD_RST_FIRE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (bod_rst_sync_q[1] && rena_q |=> chip_reset_req_out)) else $error("reset request missed");
  AST_BOD_IRQ_RSVD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (bod_irq_out |-> $past(ilev_q) != 2'h0)) else $error("interrupt with reserved level");
  AST_BOD_IRQ_FIRE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (bod_irq_sync_q[1] && ilev_q != 2'h0 |=> bod_irq_out)) else $error("brown-out interrupt missed");

  // ==========================================================================
  // minimum interrupt latency gate
  scbw_lat_state_type lat_st_q;
  scbw_lat_state_type lat_st_d;
  logic [7:0]         lat_cnt_q;
  logic [7:0]         lat_cnt_d;
  wire  [8:0]         lat_next = {1'b0, lat_cnt_q} + 9'h001;

  // hold the response until the latency count has elapsed
  always_comb begin
    lat_st_d  = lat_st_q;
    lat_cnt_d = lat_cnt_q;
    case (lat_st_q)
      SCBW_LAT_IDLE: begin
        lat_cnt_d = 8'h00;
        if (irq_req_in) begin
          lat_st_d = (lat_q == 8'h00) ? SCBW_LAT_GRANT : SCBW_LAT_COUNT;
        end
      end
      SCBW_LAT_COUNT: begin
        if (!irq_req_in) begin
          lat_st_d = SCBW_LAT_IDLE;
        end else if (lat_next >= {1'b0, lat_q}) begin
          lat_st_d = SCBW_LAT_GRANT;
        end else begin
          lat_cnt_d = lat_next[7:0];
        end
      end
      SCBW_LAT_GRANT: begin
        if (!irq_req_in) begin
          lat_st_d = SCBW_LAT_IDLE;
        end
      end
      default: begin
        lat_st_d = SCBW_LAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lat_st_q  <= SCBW_LAT_IDLE;
      lat_cnt_q <= 8'h00;
    end else begin
      lat_st_q  <= lat_st_d;
      lat_cnt_q <= lat_cnt_d;
    end
  end

  assign irq_grant_out = (lat_st_q == SCBW_LAT_GRANT) & irq_req_in;

  // helper: cycles the current request has been pending
  logic [8:0] req_age_q;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_age_q <= 9'h000;
    end else if (!irq_req_in) begin
      req_age_q <= 9'h000;
    end else if (req_age_q != 9'h1FF) begin
      req_age_q <= req_age_q + 9'h001;
    end
  end

  // grant timing checks
  AST_LAT_MIN: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ($rose(irq_grant_out) |-> req_age_q >= {1'b0, lat_q})) else $error("interrupt granted too early");
  AST_LAT_MAX: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (irq_req_in && $stable(lat_q) && req_age_q == {1'b0, lat_q} + 9'h001 |-> irq_grant_out))
    else $error("interrupt grant late");
  AST_GRANT_HOLD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (irq_grant_out ##1 irq_req_in |-> irq_grant_out)) else $error("grant dropped under a held request");

  // ==========================================================================
  // non-maskable routing, normal interrupts pass on regardless
  wire nmi_d = nmi_en_q & periph_irq_in[nmi_num_q];

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nmi_out        <= 1'b0;
      normal_irq_out <= '0;
    end else begin
      nmi_out        <= nmi_d;
      normal_irq_out <= periph_irq_in;
    end
  end

  // routing checks, normal copy always follows its input
  AST_NMI_OFF: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!nmi_en_q |=> !nmi_out)) else $error("nmi while routing disabled");
  AST_NMI_ON: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (nmi_en_q && periph_irq_in[nmi_num_q] |=> nmi_out)) else $error("selected source not routed");
  AST_NMI_BOTH: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (nmi_out |-> normal_irq_out[$past(nmi_num_q)])) else $error("normal interrupt lost beside nmi");
  AST_NMI_NORMAL: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (1'b1 |=> normal_irq_out == $past(periph_irq_in))) else $error("normal interrupt copy wrong");

  // ==========================================================================
  // wake-up start logic, one slice per pin
  logic [NUM_WAKE-1:0] wake_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE; gi++) begin : g_wake
      logic [1:0] sync_q;
      logic       prev_q;
      logic       pend_q;
      // synchronise then detect the chosen edge
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync_q <= 2'h0;
          prev_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[0], wake_pin_in[gi]};
          prev_q <= sync_q[1];
        end
      end
      assign wake_hit[gi] = wake_edge_q[gi] ? (sync_q[1] & ~prev_q)
                                            : (~sync_q[1] & prev_q);
      // latched start state, a new edge beats a clear
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          pend_q <= 1'b0;
        end else if (wake_hit[gi]) begin
          pend_q <= 1'b1;
        end else if (wake_clear_in[gi]) begin
          pend_q <= 1'b0;
        end
      end
      assign wake_irq_out[gi] = pend_q;

      // latch set, clear and hold checks
      AST_WAKE_SET: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (wake_hit[gi] |=> wake_irq_out[gi])) else $error("wake edge not latched");
      AST_WAKE_CLR: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (wake_clear_in[gi] && !wake_hit[gi] |=> !wake_irq_out[gi])) else $error("wake state not cleared");
      AST_WAKE_HOLD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (wake_irq_out[gi] && !wake_clear_in[gi] |=> wake_irq_out[gi])) else $error("wake state lost");
    end
  endgenerate

  // ==========================================================================
  // event status, write one to clear, set wins
  logic [`SCBW_EV_W-1:0] ev_set;
  assign ev_set[`SCBW_EV_BOD_IRQ] = bod_irq_d & ~bod_irq_prev_q;
  assign ev_set[`SCBW_EV_BOD_RST] = bod_rst_d & ~chip_reset_req_out;
  assign ev_set[`SCBW_EV_WAKE]    = |wake_hit;
  assign ev_set[`SCBW_EV_NMI]     = nmi_d & ~nmi_out;
  wire [`SCBW_EV_W-1:0] ev_clr = (reg_wr_in & sel_evsts) ? reg_wdata_in[`SCBW_EV_W-1:0] : 4'h0;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ev_sts_q <= 4'h0;
    end else begin
      ev_sts_q <= (ev_sts_q & ~ev_clr) | ev_set;
    end
  end

  assign irq_out = |(ev_sts_q & ev_msk_q);

  // status and read-back checks
  AST_RSVD_ZERO: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ($past(reg_rd_in && sel_wake) |-> reg_rdata_out[31:13] == 19'h0_0000)) else $error("reserved bits not zero");
  AST_NMI_RSVD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ($past(reg_rd_in && sel_nmi) |-> reg_rdata_out[30:5] == 26'h000_0000))
    else $error("reserved routing bits not zero");
  AST_EV_SET_WINS: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (ev_set != 4'h0 |=> (ev_sts_q & $past(ev_set)) == $past(ev_set)))
    else $error("event lost against a clear");
  AST_EV_CLR: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ((ev_clr & ~ev_set) != 4'h0 |=> (ev_sts_q & $past(ev_clr & ~ev_set)) == 4'h0))
    else $error("status not cleared");
  AST_RDATA_IDLE: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)) else $error("read data outside read slot");

endmodule // scbw_regs
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scbw_map.svh"
module tb_top;
  import scbw_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic            core_clk;
  logic            arst_n;
  logic [31:0]     reg_addr;
  logic [31:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_rdata;
  logic            bod_irq_cross;
  logic            bod_rst_cross;
  scbw_level_type  rst_level;
  scbw_level_type  irq_level;
  logic            bod_irq;
  logic            chip_reset_req;
  logic [25:0]     tick_cal;
  logic            irq_req;
  logic            irq_grant;
  logic [31:0]     periph_irq;
  logic [31:0]     normal_irq;
  logic            nmi;
  logic [12:0]     wake_pin;
  logic [12:0]     wake_clear;
  logic [12:0]     wake_irq;
  logic            irq;
  int              error_cnt = 0;
  int              num_checks = 0;

  scbw_regs dut (
    .core_clk_in(core_clk), .arst_n_in(arst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .bod_irq_cross_in(bod_irq_cross),
    .bod_rst_cross_in(bod_rst_cross), .brownout_reset_level_out(rst_level),
    .brownout_irq_level_out(irq_level), .bod_irq_out(bod_irq), .chip_reset_req_out(chip_reset_req),
    .core_tick_calibration_out(tick_cal), .irq_req_in(irq_req), .irq_grant_out(irq_grant),
    .periph_irq_in(periph_irq), .normal_irq_out(normal_irq), .nmi_out(nmi), .wake_pin_in(wake_pin),
    .wake_clear_in(wake_clear), .wake_irq_out(wake_irq), .irq_out(irq));

  // ==========================================================================
  // clock, compare and bus helpers
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // one-cycle write strobe; settles past the taking edge before returning
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the taking edge
  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_sync();
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    chk_val("tick_out_rst", 32'h0000_0004, 32'(tick_cal));
    chk_val("levels_rst", 32'h0, 32'({rst_level, irq_level}));
    bus_read(`SCBW_ADDR_BOD, d);
    chk_val("bod_rst", 32'h0, d);
    bus_read(`SCBW_ADDR_TICK, d);
    chk_val("tick_rst", 32'h0000_0004, d);
    bus_read(`SCBW_ADDR_LAT, d);
    chk_val("lat_rst", 32'h0000_0010, d);
    bus_read(`SCBW_ADDR_NMI, d);
    chk_val("nmi_rst", 32'h0, d);
    bus_read(`SCBW_ADDR_WAKE, d);
    chk_val("wake_rst", 32'h0, d);
    bus_read(32'h4004_8158, d);
    chk_val("unmapped_rd", 32'h0, d);
  endtask

  task automatic t_brownout();
    logic [31:0] d;
    bus_write(`SCBW_ADDR_BOD, 32'hFFFF_FFEF);
    bus_read(`SCBW_ADDR_BOD, d);
    chk_val("bod_rd", 32'h0000_000F, d);
    @(posedge core_clk);
    bod_irq_cross <= 1'b1;
    bod_rst_cross <= 1'b1;
    wait_sync();
    chk_bit("bod_irq", 1'b1, bod_irq);
    chk_bit("chip_rst_off", 1'b0, chip_reset_req);
    bus_write(`SCBW_ADDR_BOD, 32'h0000_0013);
    wait_sync();
    chk_val("levels", 32'h0000_000C, 32'({rst_level, irq_level}));
    chk_bit("bod_irq_rsvd", 1'b0, bod_irq);
    chk_bit("chip_rst_on", 1'b1, chip_reset_req);
    @(posedge core_clk);
    bod_irq_cross <= 1'b0;
    bod_rst_cross <= 1'b0;
    bus_write(`SCBW_ADDR_BOD, 32'h0);
  endtask

  task automatic t_tick();
    logic [31:0] d;
    bus_write(`SCBW_ADDR_TICK, 32'hFFFF_FFFF);
    bus_write(32'h4004_8158, 32'h0);
    bus_read(`SCBW_ADDR_TICK, d);
    chk_val("tick_rd", 32'h03FF_FFFF, d);
    chk_val("tick_out", 32'h03FF_FFFF, 32'(tick_cal));
  endtask

  task automatic t_latency();
    logic [31:0] d;
    int          lv[3] = '{0, 2, 5};
    bus_write(`SCBW_ADDR_LAT, 32'hFFFF_FFFF);
    bus_read(`SCBW_ADDR_LAT, d);
    chk_val("lat_rd", 32'h0000_00FF, d);
    for (int i = 0; i < 3; i++) begin
      bus_write(`SCBW_ADDR_LAT, 32'(lv[i]));
      @(posedge core_clk);
      irq_req <= 1'b1;
      for (int k = 1; k <= lv[i] + 1; k++) begin
        @(posedge core_clk);
        #1;
        chk_bit("irq_grant", k == lv[i] + 1, irq_grant);
      end
      @(posedge core_clk);
      irq_req <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task automatic t_nmi();
    logic [31:0] d;
    bus_write(`SCBW_ADDR_NMI, 32'h0000_0005);
    @(posedge core_clk);
    periph_irq <= 32'h0000_0020;
    repeat (2) @(posedge core_clk);
    #1;
    chk_bit("nmi_off", 1'b0, nmi);
    chk_val("normal_irq", 32'h0000_0020, normal_irq);
    bus_write(`SCBW_ADDR_NMI, 32'h8000_0005);
    @(posedge core_clk);
    #1;
    chk_bit("nmi_on", 1'b1, nmi);
    chk_val("normal_both", 32'h0000_0020, normal_irq);
    bus_write(`SCBW_ADDR_NMI, 32'hFFFF_FFFF);
    bus_read(`SCBW_ADDR_NMI, d);
    chk_val("nmi_rd", 32'h8000_001F, d);
    chk_bit("nmi_other_src", 1'b0, nmi);
    @(posedge core_clk);
    periph_irq <= 32'h0;
  endtask

  task automatic t_wake();
    logic [31:0] d;
    bus_write(`SCBW_ADDR_WAKE, 32'h0000_1001);
    bus_read(`SCBW_ADDR_WAKE, d);
    chk_val("wake_rd", 32'h0000_1001, d);
    @(posedge core_clk);
    wake_pin <= 13'h0000;
    wait_sync();
    chk_val("wake_fall", 32'h0000_0FFE, 32'(wake_irq));
    @(posedge core_clk);
    wake_pin <= 13'h1FFF;
    wait_sync();
    chk_val("wake_rise", 32'h0000_1FFF, 32'(wake_irq));
    @(posedge core_clk);
    wake_clear <= 13'h1FFF;
    @(posedge core_clk);
    wake_clear <= 13'h0000;
    @(posedge core_clk);
    #1;
    chk_val("wake_cleared", 32'h0, 32'(wake_irq));
  endtask

  task automatic t_events();
    logic [31:0] d;
    bus_read(`SCBW_ADDR_EVSTS, d);
    chk_val("ev_status", 32'h0000_000F, d);
    chk_bit("irq_masked", 1'b0, irq);
    bus_write(`SCBW_ADDR_EVMSK, 32'h0000_0004);
    chk_bit("irq_unmasked", 1'b1, irq);
    bus_write(`SCBW_ADDR_EVSTS, 32'h0000_0004);
    chk_bit("irq_w1c", 1'b0, irq);
    bus_read(`SCBW_ADDR_EVSTS, d);
    chk_val("ev_after_w1c", 32'h0000_000B, d);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    arst_n        = 1'b0;
    reg_addr      = 32'h0;
    reg_wdata     = 32'h0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    bod_irq_cross = 1'b0;
    bod_rst_cross = 1'b0;
    irq_req       = 1'b0;
    periph_irq    = 32'h0;
    wake_pin      = 13'h1FFF;
    wake_clear    = 13'h0000;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    t_reset();
    t_brownout();
    t_tick();
    t_latency();
    t_nmi();
    t_wake();
    t_events();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
